/* rtl/gpkw_defs.vh */
// gpkw_defs.vh: constants for the gpio port block with key wake-up
`ifndef GPKW_DEFS_VH
`define GPKW_DEFS_VH

// ***************************************************************
// register write selects (binary codes compared against i_wr_sel)
// ***************************************************************
`define GPKW_SEL_E_DATA     5'h0
`define GPKW_SEL_E_DIR      5'h1
`define GPKW_SEL_E_FUNC     5'h2
`define GPKW_SEL_PULL_CONTROL_REG       5'h3
`define GPKW_SEL_DRIVE_REDUCTION_REG      5'h4
`define GPKW_SEL_H_DATA     5'h5
`define GPKW_SEL_H_DIR      5'h6
`define GPKW_SEL_H_POL      5'h7
`define GPKW_SEL_H_IEN      5'h8
`define GPKW_SEL_J_DATA     5'h9
`define GPKW_SEL_J_DIR      5'ha
`define GPKW_SEL_J_POL      5'hb
`define GPKW_SEL_J_IEN      5'hc
`define GPKW_SEL_K_DATA     5'hd
`define GPKW_SEL_K_DIR      5'he
`define GPKW_SEL_IB_DIR     5'hf
`define GPKW_SEL_IB_PURD    5'h10
`define GPKW_SEL_IB_DATA    5'h11
`define GPKW_NUM_SEL        18

// ***************************************************************
// field positions in pull_control_reg and drive_reduction_reg
// ***************************************************************
`define GPKW_BIT_E          0
`define GPKW_BIT_H          1
`define GPKW_BIT_J          2
`define GPKW_BIT_K          3
// serial_bus_pull_drive_reg fields
`define GPKW_IB_PULL_BIT    0
`define GPKW_IB_RDRV_BIT    1

// ***************************************************************
// reset values and fixed masks
// ***************************************************************
`define GPKW_RST_BYTE       8'h00
`define GPKW_E_DIR_MASK     8'hfc
`define GPKW_E_PULL_MASK    8'h8f
`define GPKW_K_PAGE_MASK    8'hf7
`define GPKW_IB_FIXPU_MASK  8'h3f
`define GPKW_IB_SCL_BIT     7
`define GPKW_IB_SDA_BIT     6
`define GPKW_CAN_RX_BIT     0
`define GPKW_CAN_TX_BIT     1

`endif

/* rtl/gpkw_ports.v */
// gpkw_ports.v: i/o port logic for ports e, h, j, k, can and serial bus
`timescale 1ns/1ps
`default_nettype none
`include "gpkw_defs.vh"
module gpkw_ports #(
    parameter W      = 8,
    parameter NCAN   = 3
) (
    // clock and reset
    input  wire              i_mclk,
    input  wire              i_reset,
    // register write port
    input  wire              i_wr_en,
    input  wire [4:0]        i_wr_sel,
    input  wire [W-1:0]      i_wr_data,
    // operating mode
    input  wire              i_peripheral_mode,
    input  wire              i_expanded_mode,
    input  wire              i_port_e_emulation_enable,
    input  wire              i_page_emulation_enable,
    // alternate functions driving port e and k
    input  wire [W-1:0]      i_port_e_alt_out,
    input  wire [W-1:0]      i_port_e_alt_oe,
    input  wire [W-1:0]      i_page_index,
    // can controller side and pins
    input  wire [NCAN-1:0]   i_can_tx,
    input  wire [NCAN-1:0]   i_can_rx_pin,
    output wire [NCAN-1:0]   o_can_rx,
    output wire [2*NCAN-1:0] o_can_pair,
    output wire [NCAN-1:0]   o_can_tx_pin,
    // serial bus controller side
    input  wire              i_serial_bus_enable,
    input  wire              i_serial_scl_low,
    input  wire              i_serial_sda_low,
    // pin inputs
    input  wire [W-1:0]      i_port_e_pin,
    input  wire [W-1:0]      i_port_h_pin,
    input  wire [W-1:0]      i_port_j_pin,
    input  wire [W-1:0]      i_port_k_pin,
    input  wire [W-1:0]      i_serial_bus_pin,
    // pin outputs and enables
    output reg  [W-1:0]      o_port_e_out,
    output reg  [W-1:0]      o_port_e_oe,
    output wire [W-1:0]      o_port_h_out,
    output wire [W-1:0]      o_port_h_oe,
    output wire [W-1:0]      o_port_j_out,
    output wire [W-1:0]      o_port_j_oe,
    output reg  [W-1:0]      o_port_k_out,
    output reg  [W-1:0]      o_port_k_oe,
    output reg  [W-1:0]      o_serial_bus_out,
    output reg  [W-1:0]      o_serial_bus_oe,
    // pad controls
    output reg  [W-1:0]      o_port_e_pullup,
    output wire [W-1:0]      o_port_h_pullup,
    output wire [W-1:0]      o_port_h_pulldown,
    output wire [W-1:0]      o_port_j_pullup,
    output wire [W-1:0]      o_port_j_pulldown,
    output wire [W-1:0]      o_port_k_pullup,
    output wire [W-1:0]      o_serial_bus_pullup,
    output wire [3:0]        o_reduced_drive,
    output wire              o_serial_bus_reduced_drive,
    // status and wake-up
    output wire [3:0]        o_pull_control_reg,
    output wire [3:0]        o_drive_reduction_reg,
    output wire [1:0]        o_serial_bus_pull_drive_reg,
    output wire              o_port_e_mapped,
    output wire              o_port_k_mapped,
    output wire              o_drive_reduction_mapped,
    output wire [W-1:0]      o_port_h_wake_event,
    output wire [W-1:0]      o_port_j_wake_event,
    output wire              o_port_h_wake_irq,
    output wire              o_port_j_wake_irq,
    // read-back of pin levels
    output reg  [W-1:0]      o_port_e_in,
    output reg  [W-1:0]      o_port_h_in,
    output reg  [W-1:0]      o_port_j_in,
    output reg  [W-1:0]      o_port_k_in,
    output reg  [W-1:0]      o_serial_bus_in
);
    // ***********************************************************
    // register storage
    // ***********************************************************
    reg [W-1:0] port_e_data_r, port_e_direction_r, port_e_function_assign_r;
    reg [W-1:0] port_h_data_r, port_h_direction_r;
    reg [W-1:0] port_h_edge_polarity_r, port_h_wake_irq_enable_r;
    reg [W-1:0] port_j_data_r, port_j_direction_r;
    reg [W-1:0] port_j_edge_polarity_r, port_j_wake_irq_enable_r;
    reg [W-1:0] port_k_data_r, port_k_direction_r;
    reg [W-1:0] sb_data_r, serial_bus_port_direction_r;
    reg [3:0]   pull_control_reg_r;
    reg [3:0]   drive_reduction_reg_r;
    reg         drive_locked_r;
    reg [1:0]   serial_bus_pull_drive_reg_r;

    // decode a write strobe for one select code
    function wr_hit;
        input       en;
        input [4:0] sel;
        input [4:0] code;
        begin
            wr_hit = en && (sel == code);
        end
    endfunction

    // ***********************************************************
    // map visibility
    // ***********************************************************
    wire page_emu = (i_expanded_mode | i_peripheral_mode) &
                    i_page_emulation_enable;
    assign o_port_e_mapped = ~i_peripheral_mode &
        ~(i_expanded_mode & i_port_e_emulation_enable);
    assign o_port_k_mapped = ~page_emu;
    assign o_drive_reduction_mapped = ~i_peripheral_mode;
    wire pull_control_reg_mapped = ~i_peripheral_mode;

    // ***********************************************************
    // register writes
    // ***********************************************************
    // everything clears on reset, so gpio pins start as inputs
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            port_e_data_r               <= `GPKW_RST_BYTE;
            port_e_direction_r          <= `GPKW_RST_BYTE;
            port_e_function_assign_r    <= `GPKW_RST_BYTE;
            port_h_data_r               <= `GPKW_RST_BYTE;
            port_h_direction_r          <= `GPKW_RST_BYTE;
            port_h_edge_polarity_r      <= `GPKW_RST_BYTE;
            port_h_wake_irq_enable_r    <= `GPKW_RST_BYTE;
            port_j_data_r               <= `GPKW_RST_BYTE;
            port_j_direction_r          <= `GPKW_RST_BYTE;
            port_j_edge_polarity_r      <= `GPKW_RST_BYTE;
            port_j_wake_irq_enable_r    <= `GPKW_RST_BYTE;
            port_k_data_r               <= `GPKW_RST_BYTE;
            port_k_direction_r          <= `GPKW_RST_BYTE;
            sb_data_r                   <= `GPKW_RST_BYTE;
            serial_bus_port_direction_r <= `GPKW_RST_BYTE;
            pull_control_reg_r          <= 4'h0;
            drive_reduction_reg_r       <= 4'h0;
            drive_locked_r              <= 1'b0;
            serial_bus_pull_drive_reg_r <= 2'h0;
        end else begin
            if (o_port_e_mapped) begin
                if (wr_hit(i_wr_en, i_wr_sel, `GPKW_SEL_E_DATA))
                    port_e_data_r <= i_wr_data;
                if (wr_hit(i_wr_en, i_wr_sel, `GPKW_SEL_E_DIR))
                    port_e_direction_r <= i_wr_data;
            end
            if (wr_hit(i_wr_en, i_wr_sel, `GPKW_SEL_E_FUNC))
                port_e_function_assign_r <= i_wr_data;
            if (pull_control_reg_mapped &&
                wr_hit(i_wr_en, i_wr_sel, `GPKW_SEL_PULL_CONTROL_REG))
                pull_control_reg_r <= i_wr_data[3:0];
            // write-once: the first accepted write locks it
            if (o_drive_reduction_mapped && !drive_locked_r &&
                wr_hit(i_wr_en, i_wr_sel, `GPKW_SEL_DRIVE_REDUCTION_REG)) begin
                drive_reduction_reg_r <= i_wr_data[3:0];
                drive_locked_r        <= 1'b1;
            end
            if (wr_hit(i_wr_en, i_wr_sel, `GPKW_SEL_H_DATA))
                port_h_data_r <= i_wr_data;
            if (wr_hit(i_wr_en, i_wr_sel, `GPKW_SEL_H_DIR))
                port_h_direction_r <= i_wr_data;
            if (wr_hit(i_wr_en, i_wr_sel, `GPKW_SEL_H_POL))
                port_h_edge_polarity_r <= i_wr_data;
            if (wr_hit(i_wr_en, i_wr_sel, `GPKW_SEL_H_IEN))
                port_h_wake_irq_enable_r <= i_wr_data;
            if (wr_hit(i_wr_en, i_wr_sel, `GPKW_SEL_J_DATA))
                port_j_data_r <= i_wr_data;
            if (wr_hit(i_wr_en, i_wr_sel, `GPKW_SEL_J_DIR))
                port_j_direction_r <= i_wr_data;
            if (wr_hit(i_wr_en, i_wr_sel, `GPKW_SEL_J_POL))
                port_j_edge_polarity_r <= i_wr_data;
            if (wr_hit(i_wr_en, i_wr_sel, `GPKW_SEL_J_IEN))
                port_j_wake_irq_enable_r <= i_wr_data;
            if (o_port_k_mapped) begin
                if (wr_hit(i_wr_en, i_wr_sel, `GPKW_SEL_K_DATA))
                    port_k_data_r <= i_wr_data;
                if (wr_hit(i_wr_en, i_wr_sel, `GPKW_SEL_K_DIR))
                    port_k_direction_r <= i_wr_data;
            end
            if (wr_hit(i_wr_en, i_wr_sel, `GPKW_SEL_IB_DIR))
                serial_bus_port_direction_r <= i_wr_data;
            if (wr_hit(i_wr_en, i_wr_sel, `GPKW_SEL_IB_PURD))
                serial_bus_pull_drive_reg_r <= i_wr_data[1:0];
            if (wr_hit(i_wr_en, i_wr_sel, `GPKW_SEL_IB_DATA))
                sb_data_r <= i_wr_data;
        end
    end

    assign o_pull_control_reg          = pull_control_reg_r;
    assign o_drive_reduction_reg       = drive_reduction_reg_r;
    assign o_serial_bus_pull_drive_reg = serial_bus_pull_drive_reg_r;

    // ***********************************************************
    // port e: function assignment beats direction
    // ***********************************************************
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_port_e_out <= `GPKW_RST_BYTE;
            o_port_e_oe  <= `GPKW_RST_BYTE;
        end else begin
            // bits 1:0 are input-only: no function may enable them
            o_port_e_oe <= ((port_e_function_assign_r & i_port_e_alt_oe) |
                (~port_e_function_assign_r & port_e_direction_r)) &
                `GPKW_E_DIR_MASK;
            o_port_e_out <= (port_e_function_assign_r & i_port_e_alt_out) |
                (~port_e_function_assign_r & port_e_data_r);
        end
    end

    // pull-ups only on the pins that carry them
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset)
            o_port_e_pullup <= `GPKW_RST_BYTE;
        else
            o_port_e_pullup <= {W{pull_control_reg_r[`GPKW_BIT_E]}} &
                               `GPKW_E_PULL_MASK;
    end

    // ***********************************************************
    // ports h and j: direction, pulls and key wake-up
    // ***********************************************************
    assign o_port_h_out = port_h_data_r;
    assign o_port_h_oe  = port_h_direction_r;
    assign o_port_j_out = port_j_data_r;
    assign o_port_j_oe  = port_j_direction_r;

    // pull type follows polarity, only on input pins
    wire [W-1:0] h_pull = {W{pull_control_reg_r[`GPKW_BIT_H]}} &
                          ~port_h_direction_r;
    wire [W-1:0] j_pull = {W{pull_control_reg_r[`GPKW_BIT_J]}} &
                          ~port_j_direction_r;
    assign o_port_h_pulldown = h_pull & port_h_edge_polarity_r;
    assign o_port_h_pullup   = h_pull & ~port_h_edge_polarity_r;
    assign o_port_j_pulldown = j_pull & port_j_edge_polarity_r;
    assign o_port_j_pullup   = j_pull & ~port_j_edge_polarity_r;

    // one wake-up detector per port; pin level taken regardless
    // of direction so an output pin can wake too
    gpkw_wake_port #(.WIDTH(W)) u_wake_h (
        .i_mclk            (i_mclk),
        .i_reset           (i_reset),
        .i_edge_polarity   (port_h_edge_polarity_r),
        .i_wake_irq_enable (port_h_wake_irq_enable_r),
        .i_pin             (i_port_h_pin),
        .o_wake_event      (o_port_h_wake_event),
        .o_wake_irq        (o_port_h_wake_irq)
    );
    gpkw_wake_port #(.WIDTH(W)) u_wake_j (
        .i_mclk            (i_mclk),
        .i_reset           (i_reset),
        .i_edge_polarity   (port_j_edge_polarity_r),
        .i_wake_irq_enable (port_j_wake_irq_enable_r),
        .i_pin             (i_port_j_pin),
        .o_wake_event      (o_port_j_wake_event),
        .o_wake_irq        (o_port_j_wake_irq)
    );

    // ***********************************************************
    // port k: page index emulation or gpio
    // ***********************************************************
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_port_k_out <= `GPKW_RST_BYTE;
            o_port_k_oe  <= `GPKW_RST_BYTE;
        end else if (page_emu) begin
            // bit 3 stays gpio even while emulating
            o_port_k_oe  <= `GPKW_K_PAGE_MASK |
                            (port_k_direction_r & ~`GPKW_K_PAGE_MASK);
            o_port_k_out <= (i_page_index & `GPKW_K_PAGE_MASK) |
                            (port_k_data_r & ~`GPKW_K_PAGE_MASK);
        end else begin
            o_port_k_oe  <= port_k_direction_r;
            o_port_k_out <= port_k_data_r;
        end
    end
    assign o_port_k_pullup = {W{pull_control_reg_r[`GPKW_BIT_K]}} &
                             ~port_k_direction_r;

    // reduced drive per port, straight from the write-once register
    assign o_reduced_drive = drive_reduction_reg_r;

    // ***********************************************************
    // can pin pairs: no gpio path at all
    // ***********************************************************
    genvar g;
    generate
        for (g = 0; g < NCAN; g = g + 1) begin : g_can
            // tx low is dominant, so the controller bit passes as is
            assign o_can_tx_pin[g] = i_can_tx[g];
            assign o_can_rx[g]     = i_can_rx_pin[g];
            assign o_can_pair[2*g+`GPKW_CAN_RX_BIT] = i_can_rx_pin[g];
            assign o_can_pair[2*g+`GPKW_CAN_TX_BIT] = i_can_tx[g];
        end
    endgenerate

    // ***********************************************************
    // serial bus port: scl and sda open drain when enabled, other bits and disabled port gpio
    // ***********************************************************
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_serial_bus_out <= `GPKW_RST_BYTE;
            o_serial_bus_oe  <= `GPKW_RST_BYTE;
        end else begin
            o_serial_bus_out <= sb_data_r;
            o_serial_bus_oe  <= serial_bus_port_direction_r;
            if (i_serial_bus_enable) begin
                // drive low only, the line floats high via pull-up
                o_serial_bus_out[`GPKW_IB_SCL_BIT] <= 1'b0;
                o_serial_bus_out[`GPKW_IB_SDA_BIT] <= 1'b0;
                o_serial_bus_oe[`GPKW_IB_SCL_BIT]  <= i_serial_scl_low;
                o_serial_bus_oe[`GPKW_IB_SDA_BIT]  <= i_serial_sda_low;
            end
        end
    end
    assign o_serial_bus_pullup = `GPKW_IB_FIXPU_MASK |
        ({W{serial_bus_pull_drive_reg_r[`GPKW_IB_PULL_BIT]}} &
         ~serial_bus_port_direction_r);
    assign o_serial_bus_reduced_drive =
        serial_bus_pull_drive_reg_r[`GPKW_IB_RDRV_BIT];

    // ***********************************************************
    // pin read-back registers
    // ***********************************************************
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_port_e_in     <= `GPKW_RST_BYTE;
            o_port_h_in     <= `GPKW_RST_BYTE;
            o_port_j_in     <= `GPKW_RST_BYTE;
            o_port_k_in     <= `GPKW_RST_BYTE;
            o_serial_bus_in <= `GPKW_RST_BYTE;
        end else begin
            o_port_e_in     <= i_port_e_pin;
            o_port_h_in     <= i_port_h_pin;
            o_port_j_in     <= i_port_j_pin;
            o_port_k_in     <= i_port_k_pin;
            o_serial_bus_in <= i_serial_bus_pin;
        end
    end
endmodule
`default_nettype wire

/* rtl/gpkw_wake_port.v */
// gpkw_wake_port.v: one 8-bit key wake-up port with edge detect
`timescale 1ns/1ps
`default_nettype none
module gpkw_wake_port #(
    parameter WIDTH = 8
) (
    // clock and reset
    input  wire             i_mclk,
    input  wire             i_reset,
    // configuration
    input  wire [WIDTH-1:0] i_edge_polarity,
    input  wire [WIDTH-1:0] i_wake_irq_enable,
    // pin level, seen whatever the pin direction
    input  wire [WIDTH-1:0] i_pin,
    // outputs
    output reg  [WIDTH-1:0] o_wake_event,
    output wire             o_wake_irq
);
    reg [WIDTH-1:0] sync1_r;
    reg [WIDTH-1:0] sync2_r;
    reg [WIDTH-1:0] prev_r;
    wire [WIDTH-1:0] rise;
    wire [WIDTH-1:0] fall;

    // two-stage synchroniser then a previous-sample stage
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            sync1_r <= {WIDTH{1'b0}};
            sync2_r <= {WIDTH{1'b0}};
            prev_r  <= {WIDTH{1'b0}};
        end else begin
            sync1_r <= i_pin;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    assign rise = sync2_r & ~prev_r;
    assign fall = ~sync2_r & prev_r;

    // polarity picks the edge; detection ignores direction
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_wake_event <= {WIDTH{1'b0}};
        end else begin
            o_wake_event <= (i_edge_polarity & rise) |
                            (~i_edge_polarity & fall);
        end
    end

    // only enabled pins may request; others stay plain i/o
    assign o_wake_irq = |(o_wake_event & i_wake_irq_enable);
endmodule
`default_nettype wire

/* tb/gpkw_pin_model.sv */
// gpkw_pin_model.sv: board-side pad model resolving each port pin level
`timescale 1ns/1ps
`default_nettype none
module gpkw_pin_model (
    input  wire logic [7:0] i_out, i_oe, i_pull, i_ext,
    output wire logic [7:0] o_pin
);
    // a driven pin shows its driver, a released pulled pin idles high
    assign o_pin = (i_oe & i_out) | (~i_oe & (i_pull | i_ext));
endmodule
`default_nettype wire

/* tb/gpkw_ports_assertions.sv */
// gpkw_ports_assertions.sv: concurrent checks on the port block pins
`timescale 1ns/1ps
`default_nettype none
`include "gpkw_defs.vh"
module gpkw_ports_chk (
    input wire logic       i_mclk, i_reset, i_wr_en, i_peripheral_mode,
    input wire logic       i_serial_bus_enable, i_serial_scl_low,
    input wire logic       o_port_e_mapped, o_drive_reduction_mapped,
    input wire logic       o_port_h_wake_irq,
    input wire logic [4:0] i_wr_sel,
    input wire logic [2:0] i_can_tx, i_can_rx_pin, o_can_tx_pin,
    input wire logic [5:0] o_can_pair,
    input wire logic [3:0] o_drive_reduction_reg,
    input wire logic [7:0] i_wr_data, i_port_h_pin, o_port_e_oe, o_port_h_oe,
    input wire logic [7:0] o_serial_bus_out, o_serial_bus_oe,
    input wire logic [7:0] o_serial_bus_pullup, o_port_h_wake_event
);
    logic seen_r;
    wire  rd_wr = i_wr_en && i_wr_sel == `GPKW_SEL_DRIVE_REDUCTION_REG;
    logic [7:0] ien_r;
    always_ff @(posedge i_mclk or posedge i_reset)
        if (i_reset) ien_r <= 8'h00;
        else if (i_wr_en && i_wr_sel == `GPKW_SEL_H_IEN) ien_r <= i_wr_data;
    // remember an accepted drive write; later ones must bounce off
    always_ff @(posedge i_mclk or posedge i_reset)
        if (i_reset) seen_r <= 1'h0;
        else if (rd_wr && o_drive_reduction_mapped) seen_r <= 1'h1;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    sequence s_pulse;
        o_port_h_wake_event[0] ##1 !o_port_h_wake_event[0];
    endsequence
    property p_can_tx; o_can_tx_pin == i_can_tx; endproperty
    a_can_tx: assert property (p_can_tx) else $error("can tx level");
    property p_can_pair; o_can_pair[1:0] == {i_can_tx[0], i_can_rx_pin[0]}
        && o_can_pair[5] == i_can_tx[2]; endproperty
    a_can_pair: assert property (p_can_pair) else $error("can pair");
    property p_wake_edge; o_port_h_wake_event[0] |->
        $past(i_port_h_pin[0], 3) != $past(i_port_h_pin[0], 4); endproperty
    a_wake_edge: assert property (p_wake_edge) else $error("wake edge");
    property p_pulse; $rose(o_port_h_wake_event[0]) |-> s_pulse; endproperty
    a_pulse: assert property (p_pulse) else $error("wake pulse");
    property p_irq; o_port_h_wake_irq == |(o_port_h_wake_event & ien_r);
    endproperty
    a_irq: assert property (p_irq) else $error("irq without event");
    property p_h_dir; i_wr_en && i_wr_sel == `GPKW_SEL_H_DIR
        |=> o_port_h_oe == $past(i_wr_data); endproperty
    a_h_dir: assert property (p_h_dir) else $error("h direction");
    property p_once; seen_r && rd_wr |=> $stable(o_drive_reduction_reg);
    endproperty
    a_once: assert property (p_once) else $error("drive rewritten");
    property p_periph; i_peripheral_mode
        |-> !o_drive_reduction_mapped && !o_port_e_mapped; endproperty
    a_periph: assert property (p_periph) else $error("mapped");
    property p_e_in; o_port_e_oe[1:0] == 2'h0; endproperty
    a_e_in: assert property (p_e_in) else $error("e input pins");
    property p_scl; i_serial_bus_enable && i_serial_scl_low
        |=> o_serial_bus_oe[7] && !o_serial_bus_out[7]; endproperty
    a_scl: assert property (p_scl) else $error("scl drive");
    property p_fix_pu; o_serial_bus_pullup[5:0] == 6'h3f; endproperty
    a_fix_pu: assert property (p_fix_pu) else $error("fixed pulls");
endmodule
bind gpkw_ports gpkw_ports_chk u_chk (.*);
`default_nettype wire

/* tb/tb.sv */
// tb.sv: self-checking testbench for the port block
`timescale 1ns/1ps
`default_nettype none
`include "gpkw_defs.vh"
module tb;
    logic i_mclk = '0, i_reset = '1, i_wr_en = '0, i_peripheral_mode = '0;
    logic i_expanded_mode = '0, i_port_e_emulation_enable = '0;
    logic i_page_emulation_enable = '0, i_serial_bus_enable = '0;
    logic i_serial_scl_low = '0, i_serial_sda_low = '0, o_port_h_wake_irq;
    logic o_serial_bus_reduced_drive, o_port_e_mapped, o_port_k_mapped;
    logic o_drive_reduction_mapped, o_port_j_wake_irq;
    logic [4:0] i_wr_sel = '0;
    logic [2:0] i_can_tx = '0, i_can_rx_pin = '0, o_can_rx, o_can_tx_pin;
    logic [5:0] o_can_pair;
    logic [3:0] o_reduced_drive, o_pull_control_reg, o_drive_reduction_reg;
    logic [1:0] o_serial_bus_pull_drive_reg;
    logic [7:0] i_wr_data = '0, i_port_e_alt_out = '0, i_port_e_alt_oe = '0;
    logic [7:0] i_page_index = '0, ext = '0, o_port_e_out, o_port_e_oe;
    logic [7:0] o_port_h_out, o_port_h_oe, o_port_j_out, o_port_j_oe;
    logic [7:0] o_port_k_out, o_port_k_oe, o_serial_bus_out, o_serial_bus_oe;
    logic [7:0] o_port_e_pullup, o_port_h_pullup, o_port_h_pulldown;
    logic [7:0] o_port_j_pullup, o_port_j_pulldown, o_port_k_pullup;
    logic [7:0] o_serial_bus_pullup, o_port_h_wake_event, o_port_j_wake_event;
    logic [7:0] o_port_e_in, o_port_h_in, o_port_j_in, o_port_k_in;
    logic [7:0] o_serial_bus_in;
    wire  [7:0] i_port_e_pin, i_port_h_pin, i_port_j_pin, i_port_k_pin;
    wire  [7:0] i_serial_bus_pin;
    int miscompares = 0, num_checks = 0;
    gpkw_ports u_gpkw_ports (.*);
    gpkw_pin_model u_h (.i_out(o_port_h_out), .i_oe(o_port_h_oe),
        .i_pull(o_port_h_pullup), .i_ext(ext), .o_pin(i_port_h_pin));
    gpkw_pin_model u_ib (.i_out(o_serial_bus_out), .i_oe(o_serial_bus_oe),
        .i_pull(o_serial_bus_pullup), .i_ext(ext), .o_pin(i_serial_bus_pin));
    // the quiet ports see plain board levels
    assign i_port_e_pin = ext;
    assign i_port_j_pin = ~ext;
    assign i_port_k_pin = ext;
    // 25 mhz clock
    always #20 i_mclk = ~i_mclk;
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one write strobe, launched and dropped just after rising edges
    task automatic wr(input logic [4:0] sel, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr_en <= 1'h1;
        i_wr_sel <= sel;
        i_wr_data <= d;
        @(posedge i_mclk);
        i_wr_en <= 1'h0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic watch(input logic [7:0] d, ev_exp, input logic irq_exp);
        logic [7:0] ev;
        logic irq;
        ev = 8'h00;
        irq = 1'h0;
        wr(`GPKW_SEL_H_DATA, d);
        repeat (6) begin
            @(negedge i_mclk);
            ev = ev | o_port_h_wake_event;
            irq = irq | o_port_h_wake_irq;
        end
        chk("wake_event", ev, ev_exp);
        chk("wake_irq", {7'h00, irq}, {7'h00, irq_exp});
    endtask
    task automatic t_pull;
        wr(`GPKW_SEL_PULL_CONTROL_REG, 8'h0f);
        tick(1);
        chk("h_pullup", o_port_h_pullup, 8'hff);
        chk("e_pullup", o_port_e_pullup, 8'h8f);
        chk("k_pullup", o_port_k_pullup, 8'hff);
        wr(`GPKW_SEL_H_POL, 8'h33);
        wr(`GPKW_SEL_H_DIR, 8'h0f);
        wr(`GPKW_SEL_K_DIR, 8'h0f);
        tick(1);
        chk("h_pullup", o_port_h_pullup, 8'hc0);
        chk("h_pulldown", o_port_h_pulldown, 8'h30);
        chk("k_pullup", o_port_k_pullup, 8'hf0);
        $display("test pull done");
    endtask
    task automatic t_dir;
        wr(`GPKW_SEL_E_DIR, 8'hff);
        wr(`GPKW_SEL_IB_DIR, 8'h3c);
        tick(1);
        chk("e_oe", o_port_e_oe, 8'hfc);
        chk("k_oe", o_port_k_oe, 8'h0f);
        chk("ib_oe", o_serial_bus_oe, 8'h3c);
        wr(`GPKW_SEL_E_FUNC, 8'h83);
        i_port_e_alt_oe <= 8'h03;
        tick(1);
        chk("e_oe_func", o_port_e_oe, 8'h7c);
        $display("test direction done");
    endtask
    task automatic t_misc;
        wr(`GPKW_SEL_H_IEN, 8'h01);
        watch(8'h01, 8'h01, 1'h1);
        watch(8'h03, 8'h02, 1'h0);
        watch(8'h06, 8'h00, 1'h0);
        watch(8'h02, 8'h04, 1'h0);
        wr(`GPKW_SEL_DRIVE_REDUCTION_REG, 8'h05);
        wr(`GPKW_SEL_DRIVE_REDUCTION_REG, 8'h0a);
        wr(`GPKW_SEL_IB_PURD, 8'h02);
        i_serial_bus_enable <= 1'h1;
        i_serial_scl_low <= 1'h1;
        i_can_tx <= 3'h5;
        i_can_rx_pin <= 3'h2;
        tick(2);
        chk("drive_reg", o_drive_reduction_reg, 8'h05);
        chk("ib_rdrv", o_serial_bus_reduced_drive, 8'h01);
        chk("ib_oe", o_serial_bus_oe, 8'hbc);
        chk("ib_out", o_serial_bus_out, 8'h00);
        chk("can_tx", o_can_tx_pin, 8'h05);
        chk("can_pair", o_can_pair, 8'h26);
        chk("can_rx", o_can_rx, 8'h02);
        chk("regs", {o_pull_control_reg, o_reduced_drive}, 8'hf5);
        @(posedge i_mclk);
        i_peripheral_mode <= 1'h1;
        i_page_emulation_enable <= 1'h1;
        i_page_index <= 8'hff;
        tick(2);
        chk("maps", {o_port_e_mapped, o_port_k_mapped}, 8'h00);
        chk("k_out", o_port_k_out, 8'hf7);
        $display("test wake drive serial can map done");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // main sequence: three cycles of reset, then the scenarios
    initial begin
        repeat (3) @(posedge i_mclk);
        i_reset <= 1'h0;
        tick(1);
        chk("ib_pullup", o_serial_bus_pullup, 8'h3f);
        t_pull;
        t_dir;
        t_misc;
        end_sim;
    end
    // watchdog well beyond the seventy or so cycles the tests need
    initial begin
        #40000;
        miscompares++;
        end_sim;
    end
endmodule
`default_nettype wire
